// [dv/sie_model.sv]
// Behavioural serial interface engine that pulses transfer events.
`timescale 1ns/100ps
module sie_model
  import tx_flags_pkg::*;
#(
  parameter int EP_W = 3
) (
  input  wire logic            pclk,
  output logic      [EP_W-1:0] sie_ep,
  output logic                 sie_ack,
  output logic                 sie_nak,
  output logic                 sie_underrun,
  output logic                 sof
);
  // Idle: no event, endpoint zero.
  initial begin
    sie_ep       = '0;
    sie_ack      = 1'b0;
    sie_nak      = 1'b0;
    sie_underrun = 1'b0;
    sof          = 1'b0;
  end

  // One event pulse lasting one cycle; ev is {sof, urf, nak, ack}.
  // The gap stretches the idle time so slow answers are seen too.
  task automatic pulse(input logic [EP_W-1:0] ep, input logic [3:0] ev,
                       input int gap);
    @(posedge pclk);
    sie_ep <= ep;
    {sof, sie_underrun, sie_nak, sie_ack} <= ev;
    @(posedge pclk);
    {sof, sie_underrun, sie_nak, sie_ack} <= 4'h0;
    repeat (gap) @(posedge pclk);
  endtask
endmodule // sie_model

// [dv/test_tx_fifo_data_set_flags.sv]
// Register-level testbench for the transmit FIFO data-set flags.
`timescale 1ns/100ps
module test_tx_fifo_data_set_flags
  import tx_flags_pkg::*;
;
  logic        pclk    = 1'b0;  // Bus clock.
  logic        presetn = 1'b0;  // Active-low reset.
  logic        psel    = 1'b0;  // Select.
  logic        penable = 1'b0;  // Access phase.
  logic        pwrite  = 1'b0;  // Direction.
  logic [7:0]  paddr   = 8'h00; // Byte address.
  logic [31:0] pwdata  = '0;    // Write data.
  logic [31:0] prdata;          // Read data.
  logic        pready;          // Transfer done.
  logic        pslverr;         // Error response.
  logic [2:0]  sie_ep;          // Event endpoint.
  logic        sie_ack;         // Acked transfer.
  logic        sie_nak;         // Naked transfer.
  logic        sie_underrun;    // Read from empty.
  logic        sof;             // Start of frame.
  logic        sie_data_ready;  // Set ready to send.
  logic        irq;             // Interrupt line.
  logic [31:0] rdat;            // Last read data.
  logic        rerr;            // Last error flag.
  int          bad_count  = 0;  // Mismatches.
  int          num_checks = 0;  // Comparisons.

  // Clock of 100 MHz.
  always #5 pclk = ~pclk;

  tx_fifo_data_set_flags #(.EP_W(3), .FIFO_SIZE(64)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sie_ep(sie_ep),
    .sie_ack(sie_ack), .sie_nak(sie_nak), .sie_underrun(sie_underrun),
    .sof(sof), .sie_data_ready(sie_data_ready), .irq(irq)
  );

  sie_model #(.EP_W(3)) sie_u (
    .pclk(pclk), .sie_ep(sie_ep), .sie_ack(sie_ack), .sie_nak(sie_nak),
    .sie_underrun(sie_underrun), .sof(sof)
  );

  // Flag byte from presence, empty, underrun and overrun.
  function automatic logic [7:0] fx(input logic [1:0] p, input logic e,
                                    input logic u, input logic o);
    fx = {p, 2'b00, e, 1'b0, u, o};
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer: setup, then access until pready is sampled high.
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(a, 1'b0, 8'h00);
    chk(rdat, {24'h0, exp});
  endtask

  // Prints counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(FLAGS_OFS, FLAGS_RST);
    rd(CTRL_OFS, CTRL_RST);
    wr(IMASK_OFS, 8'h00);
    // Endpoint 0: a byte clears empty, counts fill both sets.
    wr(DATA_OFS, 8'h5a);
    rd(FLAGS_OFS, fx(2'b00, 1'b0, 1'b0, 1'b0));
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b01, 1'b1, 1'b0, 1'b0));
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b11, 1'b1, 1'b0, 1'b0));
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b11, 1'b1, 1'b0, 1'b1));
    wr(FLAGS_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b11, 1'b1, 1'b0, 1'b1));
    // Interrupt: overrun and queued events, mask, then clear.
    rd(ISTAT_OFS, 8'h09);
    chk({31'h0, irq}, 32'h0);
    wr(IMASK_OFS, 8'h01);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(ISTAT_OFS, 8'h0f);
    rd(ISTAT_OFS, 8'h00);
    chk({31'h0, irq}, 32'h0);
    // Endpoint 1 keeps its own flags while endpoint 0 holds two sets.
    wr(SEL_OFS, 8'h01);
    rd(FLAGS_OFS, FLAGS_RST);
    wr(SEL_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b11, 1'b1, 1'b0, 1'b1));
    // Endpoint 0 flush clears overrun and keeps automatic mode.
    wr(CTRL_OFS, 8'h84);
    rd(FLAGS_OFS, FLAGS_RST);
    rd(CTRL_OFS, CTRL_RST);
    // Manual advance and reverse, so the checks on endpoint 0 see them.
    wr(CTRL_OFS, 8'h00);
    wr(COUNT_OFS, 8'h00);
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b11, 1'b1, 1'b0, 1'b0));
    wr(CTRL_OFS, 8'h02);
    rd(CTRL_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b10, 1'b1, 1'b0, 1'b0));
    wr(CTRL_OFS, 8'h01);
    rd(FLAGS_OFS, fx(2'b10, 1'b1, 1'b0, 1'b0));
    wr(CTRL_OFS, 8'h02);
    rd(FLAGS_OFS, FLAGS_RST);
    wr(CTRL_OFS, 8'h02);
    rd(FLAGS_OFS, FLAGS_RST);
    // ACK and NAK on a single set under automatic management.
    wr(CTRL_OFS, 8'h04);
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b01, 1'b1, 1'b0, 1'b0));
    sie_u.pulse(3'd0, 4'h1, 0);
    rd(FLAGS_OFS, FLAGS_RST);
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b01, 1'b1, 1'b0, 1'b0));
    sie_u.pulse(3'd0, 4'h2, 3);
    rd(FLAGS_OFS, fx(2'b01, 1'b1, 1'b0, 1'b0));
    chk({31'h0, sie_data_ready}, 32'h1);
    // Isochronous after a flush: USB changes wait for start of frame.
    wr(CTRL_OFS, 8'h8c);
    rd(CTRL_OFS, 8'h0c);
    wr(COUNT_OFS, 8'h00);
    rd(FLAGS_OFS, fx(2'b01, 1'b1, 1'b0, 1'b0));
    sie_u.pulse(3'd0, 4'h1, 0);
    rd(FLAGS_OFS, fx(2'b01, 1'b1, 1'b0, 1'b0));
    sie_u.pulse(3'd0, 4'h8, 0);
    rd(FLAGS_OFS, FLAGS_RST);
    wr(DATA_OFS, 8'ha5);
    rd(FLAGS_OFS, fx(2'b00, 1'b0, 1'b0, 1'b0));
    sie_u.pulse(3'd0, 4'h4, 0);
    rd(FLAGS_OFS, fx(2'b00, 1'b0, 1'b0, 1'b0));
    sie_u.pulse(3'd0, 4'h8, 0);
    rd(FLAGS_OFS, fx(2'b00, 1'b0, 1'b1, 1'b0));
    // Unmapped address answers with an error and zero data.
    apb(8'h1c, 1'b0, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    end_of_test;
  end
endmodule // test_tx_fifo_data_set_flags

// [pkg/tx_flags_pkg.sv]
// Shared constants and types for the transmit FIFO data-set flag block.
package tx_flags_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] SEL_OFS    = 8'h00;
  localparam logic [7:0] FLAGS_OFS  = 8'h04;
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  localparam logic [7:0] DATA_OFS   = 8'h10;
  localparam logic [7:0] ISTAT_OFS  = 8'h14;
  localparam logic [7:0] IMASK_OFS  = 8'h18;

  // Field positions of the flag register.
  localparam int PRES_HI  = 7;
  localparam int PRES_LO  = 6;
  localparam int EMPTY_B  = 3;
  localparam int FULL_B   = 2;
  localparam int URF_B    = 1;
  localparam int OVF_B    = 0;

  // Field positions of the control register.
  localparam int CLR_B    = 7;
  localparam int ISO_B    = 3;
  localparam int ATM_B    = 2;
  localparam int ADV_B    = 1;
  localparam int REV_B    = 0;

  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h08;
  localparam logic [7:0] CTRL_RST  = 8'h04;

  // Interrupt event bits.
  localparam int IRQ_W    = 4;
  localparam int EV_OVF   = 0;
  localparam int EV_URF   = 1;
  localparam int EV_SENT  = 2;
  localparam int EV_QUEUE = 3;

  // Width of the per-set byte counter, enough for the largest FIFO.
  localparam int BYTES_W  = 11;
  localparam int MAX_FIFO = 1024;

  // Presence encodings.
  localparam logic [1:0] PRES_NONE = 2'h0;
  localparam logic [1:0] PRES_BOTH = 2'h3;

  // APB request as seen by the slave.
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [7:0] pwdata;
  } apb_req_t;

  // Per-endpoint flag and control state.
  typedef struct packed {
    logic [1:0]         pres;     // Data sets present, bit1 set 1.
    logic               wr_sel;   // Set slot filled by the next count.
    logic               rd_sel;   // Oldest set slot.
    logic               ovf;      // Overrun flag.
    logic               urf;      // Underrun flag.
    logic [1:0]         pend_dec; // Removals waiting for SOF.
    logic               pend_urf; // Underrun waiting for SOF.
    logic [BYTES_W-1:0] bytes;    // Bytes in the set being written.
    logic               clr;      // Flush request.
    logic               iso;      // Isochronous mode.
    logic               auto_tx_management;      // Automatic transmit management.
    logic               adv;      // Advance marker request.
    logic               rev;      // Reverse pointer request.
  } ep_state_t;

endpackage : tx_flags_pkg

// [src/irq_sticky.sv]
// Sticky interrupt status with mask and one level output.
`timescale 1ns/100ps
module irq_sticky
  import tx_flags_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [IRQ_W-1:0] events,
  input  wire logic             wr_status,
  input  wire logic             wr_mask,
  input  wire logic [7:0]       wdata,
  output logic      [IRQ_W-1:0] status,
  output logic      [IRQ_W-1:0] mask,
  output logic                  irq
);

  typedef struct packed {
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
  } irq_state_t;

  irq_state_t st_r;   // Registered state.
  irq_state_t st_nxt; // Next state.

  // Writing one clears a status bit; a same-cycle event wins.
  always_comb begin
    st_nxt = st_r;
    if (wr_status) begin
      st_nxt.status = st_r.status & ~wdata[IRQ_W-1:0];
    end
    st_nxt.status = st_nxt.status | events;
    if (wr_mask) begin
      st_nxt.mask = wdata[IRQ_W-1:0];
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign mask   = st_r.mask;
  assign irq    = |(st_r.status & st_r.mask);

endmodule // irq_sticky

// [src/presence_step.sv]
// Next data-set presence after removals and one possible addition.
`timescale 1ns/100ps
module presence_step
  import tx_flags_pkg::*;
(
  input  wire logic [1:0] pres,
  input  wire logic       wr_sel,
  input  wire logic       rd_sel,
  input  wire logic       inc,
  input  wire logic [1:0] dec_n,
  output logic      [1:0] pres_o,
  output logic            wr_sel_o,
  output logic            rd_sel_o,
  output logic            ovf_o
);

  // Removals come first, oldest slot first; then the addition fills the
  // slot the writer points at, or raises overrun when both are held.
  always_comb begin
    logic [1:0] p;
    logic       r;
    logic       w;
    p = pres;
    r = rd_sel;
    w = wr_sel;
    ovf_o = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // Each removal clears the oldest occupied slot.
      if (2'(i) < dec_n && p != PRES_NONE) begin
        if (!p[r]) begin
          r = ~r;
        end
        p[r] = 1'b0;
        r = ~r;
      end
    end
    // An empty FIFO refills from set 0, so 00 becomes 01.
    if (p == PRES_NONE) begin
      r = 1'b0;
      w = 1'b0;
    end
    if (inc) begin
      // A third set cannot be held.
      if (p == PRES_BOTH) begin
        ovf_o = 1'b1;
      end else begin
        if (p[w]) begin
          w = ~w;
        end
        p[w] = 1'b1;
        w = ~w;
      end
    end
    pres_o   = p;
    wr_sel_o = w;
    rd_sel_o = r;
  end

endmodule // presence_step

// [src/tx_fifo_data_set_flags.sv]
// Endpoint-indexed transmit FIFO data-set flags behind an APB slave.
// Overview of operation
// - Flags shown for the selected endpoint's FIFO.
// - Bits 7:6 mark which sets present.
// - Byte count write adds a set; overrun.
// - Marker advance removes oldest set in order.
// - Advance by firmware or automatic both clear.
// - Iso: firmware changes now, USB at SOF.
// - Iso: count write now, USB removal at SOF.
// - Bit 3 empty until bytes written.
// - Empty flag always live, never deferred.
// - Overrun on byte to full or third count.
// - Advance request moves marker in manual mode without reverse, then self-clears.
// - Automatic: ACK advances marker, NAK leaves it.
`timescale 1ns/100ps
module tx_fifo_data_set_flags
  import tx_flags_pkg::*;
#(
  parameter int EP_W      = 3,
  parameter int FIFO_SIZE = 64
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [EP_W-1:0] sie_ep,
  input  wire logic            sie_ack,
  input  wire logic            sie_nak,
  input  wire logic            sie_underrun,
  input  wire logic            sof,
  output logic                 sie_data_ready,
  output logic                 irq
);

  localparam int NUM_EP = 1 << EP_W;

  // Refuse sizes the counters cannot hold.
  if (EP_W < 1 || EP_W > 4 || FIFO_SIZE < 1 || FIFO_SIZE > MAX_FIFO) begin
    $error("tx_fifo_data_set_flags: unsupported EP_W or FIFO_SIZE");
  end

  localparam logic [BYTES_W-1:0] FULL_CNT = BYTES_W'(FIFO_SIZE);

  typedef struct packed {
    ep_state_t [NUM_EP-1:0] ep;     // Per-endpoint state.
    logic [EP_W-1:0]        sel;    // Endpoint selector.
    logic [7:0]             rdata;  // Read data captured at setup.
    logic                   slverr; // Unmapped address seen at setup.
  } top_state_t;

  top_state_t st_r;   // Registered state.
  top_state_t st_nxt; // Next state.
  apb_req_t   req;    // Bus request bundle.

  // Flag register view of one endpoint; bits 5:4 read as zero.
  function automatic logic [7:0] flag_byte(input ep_state_t e);
    logic [7:0] b;
    b = 8'h00;
    b[PRES_HI:PRES_LO] = e.pres;
    b[EMPTY_B] = (e.bytes == '0);
    b[FULL_B]  = (e.bytes == FULL_CNT);
    b[URF_B]   = e.urf;
    b[OVF_B]   = e.ovf;
    return b;
  endfunction

  // Control register view of one endpoint.
  function automatic logic [7:0] ctrl_byte(input ep_state_t e);
    logic [7:0] b;
    b = 8'h00;
    b[CLR_B] = e.clr;
    b[ISO_B] = e.iso;
    b[ATM_B] = e.auto_tx_management;
    b[ADV_B] = e.adv;
    b[REV_B] = e.rev;
    return b;
  endfunction

  // Saturating two-bit add used for removal counts.
  function automatic logic [1:0] sat_add(input logic [1:0] a,
                                         input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > 3'd2) ? 2'd2 : s[1:0];
  endfunction

  // Address decode used at setup capture; the access phase reports its stored result.
  function automatic logic mapped(input logic [7:0] a);
    return a == SEL_OFS || a == FLAGS_OFS || a == CTRL_OFS ||
           a == COUNT_OFS || a == DATA_OFS || a == ISTAT_OFS ||
           a == IMASK_OFS;
  endfunction

  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata[7:0];

  logic setup_ph;  // Setup cycle of any transfer.
  logic wr_acc;    // Write taking effect this edge.
  logic wr_sel_ev; // Selector write.
  logic wr_ctrl;   // Control write.
  logic wr_cnt;    // Byte count write.
  logic wr_byte;   // FIFO data byte write.
  logic wr_istat;  // Interrupt status write.
  logic wr_imask;  // Interrupt mask write.

  assign setup_ph  = req.psel && !req.penable;
  assign wr_acc    = req.psel && req.penable && req.pwrite;
  assign wr_sel_ev = wr_acc && req.paddr == SEL_OFS;
  assign wr_ctrl   = wr_acc && req.paddr == CTRL_OFS;
  assign wr_cnt    = wr_acc && req.paddr == COUNT_OFS;
  assign wr_byte   = wr_acc && req.paddr == DATA_OFS;
  assign wr_istat  = wr_acc && req.paddr == ISTAT_OFS;
  assign wr_imask  = wr_acc && req.paddr == IMASK_OFS;

  logic [NUM_EP-1:0] inc_v;    // Count write per endpoint.
  logic [1:0]        decn_v [NUM_EP];  // Removals applied now.
  logic [1:0]        pres_v [NUM_EP];  // Stepped presence.
  logic [NUM_EP-1:0] wsel_v;   // Stepped write slot.
  logic [NUM_EP-1:0] rsel_v;   // Stepped read slot.
  logic [NUM_EP-1:0] sovf_v;   // Overrun from a third count.
  logic [NUM_EP-1:0] fwadv_v;  // Firmware advance acting now.
  logic [NUM_EP-1:0] usbdec_v; // Acknowledged send with AUTO_TX_MANAGEMENT.
  logic [IRQ_W-1:0]  events;   // Interrupt events this cycle.
  logic [IRQ_W-1:0]  istat;    // Interrupt status view.
  logic [IRQ_W-1:0]  imask;    // Interrupt mask view.

  // Per-endpoint event decode and the presence stepper.
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    logic [1:0] now_dec;  // Removals that apply in this cycle.
    assign inc_v[e] = wr_cnt && st_r.sel == EP_W'(e) && !st_r.ep[e].clr;
    // Advance effective only when others clear.
    assign fwadv_v[e] = st_r.ep[e].adv && !st_r.ep[e].rev &&
                        !st_r.ep[e].auto_tx_management && !st_r.ep[e].clr;
    // ACK advances marker; NAK changes nothing.
    assign usbdec_v[e] = sie_ack && sie_ep == EP_W'(e) &&
                         st_r.ep[e].auto_tx_management && !st_r.ep[e].clr;
    // Iso removals wait for SOF; firmware ones do not.
    always_comb begin
      now_dec = {1'b0, fwadv_v[e]};
      if (st_r.ep[e].iso) begin
        if (sof) begin
          now_dec = sat_add(now_dec, st_r.ep[e].pend_dec);
        end
      end else begin
        now_dec = sat_add(now_dec, {1'b0, usbdec_v[e]});
      end
    end
    assign decn_v[e] = now_dec;

    // Both advance sources clear a presence bit.
    presence_step u_step (
      .pres     (st_r.ep[e].pres),
      .wr_sel   (st_r.ep[e].wr_sel),
      .rd_sel   (st_r.ep[e].rd_sel),
      .inc      (inc_v[e]),
      .dec_n    (decn_v[e]),
      .pres_o   (pres_v[e]),
      .wr_sel_o (wsel_v[e]),
      .rd_sel_o (rsel_v[e]),
      .ovf_o    (sovf_v[e])
    );
  end

  // Next state: bus capture and per-endpoint flag updates.
  always_comb begin
    ep_state_t c;
    ep_state_t n;
    c = '0;
    n = '0;
    st_nxt = st_r;
    events = '0;
    // Read data and error are captured in setup, shown in access.
    if (setup_ph) begin
      st_nxt.slverr = !mapped(req.paddr);
      c = st_r.ep[st_r.sel];
      case (req.paddr)
        SEL_OFS:   st_nxt.rdata = 8'(st_r.sel);
        // Flags read from the selected endpoint.
        FLAGS_OFS: st_nxt.rdata = flag_byte(c);
        CTRL_OFS:  st_nxt.rdata = ctrl_byte(c);
        ISTAT_OFS: st_nxt.rdata = 8'(istat);
        IMASK_OFS: st_nxt.rdata = 8'(imask);
        default:   st_nxt.rdata = 8'h00;
      endcase
    end
    if (wr_sel_ev) begin
      st_nxt.sel = req.pwdata[EP_W-1:0];
    end
    for (int e = 0; e < NUM_EP; e++) begin
      c = st_r.ep[e];
      n = c;
      n.pres   = pres_v[e];
      n.wr_sel = wsel_v[e];
      n.rd_sel = rsel_v[e];
      n.adv = 1'b0;
      n.rev = 1'b0;
      if (sovf_v[e]) begin
        n.ovf = 1'b1;
      end
      // Byte writes fill the set being written.
      if (wr_byte && st_r.sel == EP_W'(e) && !c.clr) begin
        if (c.bytes == FULL_CNT) begin
          // Byte into a full FIFO overruns.
          n.ovf = 1'b1;
        end else begin
          n.bytes = BYTES_W'(c.bytes + 1'b1);
        end
      end
      // A count write starts a fresh, empty set.
      if (inc_v[e]) begin
        n.bytes = '0;
      end
      // Iso USB changes are parked until SOF.
      if (c.iso) begin
        n.pend_dec = sof ? {1'b0, usbdec_v[e]}
                         : sat_add(c.pend_dec, {1'b0, usbdec_v[e]});
        n.pend_urf = sof ? 1'b0 : c.pend_urf;
        if (sof && c.pend_urf) begin
          n.urf = 1'b1;
        end
        if (sie_underrun && sie_ep == EP_W'(e)) begin
          n.pend_urf = 1'b1;
        end
      end else begin
        n.pend_dec = '0;
        n.pend_urf = 1'b0;
        if (sie_underrun && sie_ep == EP_W'(e)) begin
          n.urf = 1'b1;
        end
      end
      // Control register write for the selected endpoint.
      if (wr_ctrl && st_r.sel == EP_W'(e)) begin
        n.clr = req.pwdata[CLR_B];
        n.iso = req.pwdata[ISO_B];
        n.auto_tx_management = req.pwdata[ATM_B];
        n.adv = req.pwdata[ADV_B];
        n.rev = req.pwdata[REV_B];
      end
      // Flush wins over everything else, then clears itself.
      if (c.clr) begin
        n = '0;
        n.iso = c.iso;
        n.auto_tx_management = c.auto_tx_management;
      end
      if (n.ovf && !c.ovf) begin
        events[EV_OVF] = 1'b1;
      end
      if (n.urf && !c.urf) begin
        events[EV_URF] = 1'b1;
      end
      if (decn_v[e] != 2'd0 && c.pres != PRES_NONE && !c.clr) begin
        events[EV_SENT] = 1'b1;
      end
      if (inc_v[e]) begin
        events[EV_QUEUE] = 1'b1;
      end
      st_nxt.ep[e] = n;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      for (int e = 0; e < NUM_EP; e++) begin
        st_r.ep[e].auto_tx_management <= CTRL_RST[ATM_B];
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // Interrupt status and mask.
  irq_sticky u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .events    (events),
    .wr_status (wr_istat),
    .wr_mask   (wr_imask),
    .wdata     (req.pwdata),
    .status    (istat),
    .mask      (imask),
    .irq       (irq)
  );

  // Zero-wait slave; errors on unmapped addresses.
  assign pready  = 1'b1;
  assign prdata  = {24'h000000, st_r.rdata};
  assign pslverr = req.psel && req.penable && st_r.slverr;

  // A set is offered to the SIE only with no FIFO error pending.
  assign sie_data_ready = st_r.ep[sie_ep].pres != PRES_NONE &&
                          !st_r.ep[sie_ep].ovf && !st_r.ep[sie_ep].urf;

  ep_state_t  e0;        // Endpoint 0 state for checks.
  ep_state_t  es;        // Selected endpoint state for checks.
  logic [7:0] sel_flags; // Selected endpoint flag byte.
  assign e0 = st_r.ep[0];
  assign es = st_r.ep[st_r.sel];
  assign sel_flags = flag_byte(es);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sel_view_a: assert property (
    setup_ph && paddr == FLAGS_OFS |=> prdata[7:0] == $past(sel_flags))
    else $error("flag read does not show selected endpoint");
  rsvd_zero_a: assert property (
    setup_ph && paddr == FLAGS_OFS |=> prdata[5:4] == 2'b00)
    else $error("reserved flag bits not zero");
  count_add_a: assert property (
    inc_v[0] && e0.pres == 2'b00 && decn_v[0] == 2'd0
    |=> e0.pres == 2'b01 ##1 e0.bytes == '0 || e0.pres != 2'b00)
    else $error("count write did not add set 0");
  third_ovf_a: assert property (
    inc_v[0] && e0.pres == PRES_BOTH && decn_v[0] == 2'd0
    |=> e0.ovf && e0.pres == PRES_BOTH)
    else $error("third data set did not raise overrun");
  ack_remove_a: assert property (
    usbdec_v[0] && !e0.iso && !e0.adv && !inc_v[0] && e0.pres == 2'b01
    |=> e0.pres == 2'b00)
    else $error("acknowledged set not removed");
  iso_defer_a: assert property (
    e0.iso && usbdec_v[0] && !sof && !e0.adv && !inc_v[0]
    |=> $stable(e0.pres) && e0.pend_dec != 2'd0)
    else $error("iso removal not deferred to SOF");
  sof_apply_a: assert property (
    e0.iso && sof && e0.pend_dec != 2'd0 && e0.pres == 2'b01 &&
    !inc_v[0] && !e0.clr |=> e0.pres == 2'b00)
    else $error("pending removal not applied at SOF");
  urf_defer_a: assert property (
    e0.iso && sie_underrun && sie_ep == '0 && !sof && !e0.urf &&
    !e0.clr |=> !e0.urf)
    else $error("iso underrun not deferred");
  adv_self_a: assert property (
    e0.adv && !wr_ctrl |=> !e0.adv)
    else $error("advance request did not self-clear");
  rev_keep_a: assert property (
    e0.rev && !inc_v[0] && decn_v[0] == 2'd0 |=> $stable(e0.pres))
    else $error("pointer reversal changed presence");
  empty_live_a: assert property (
    wr_byte && st_r.sel == '0 && !e0.clr && e0.bytes != FULL_CNT
    |=> !sel_flags[EMPTY_B])
    else $error("empty flag did not clear on byte write");

  two_sets_c: cover property (e0.pres == PRES_BOTH);
  iso_sof_c:  cover property (e0.iso && sof && e0.pend_dec != 2'd0);
  overrun_c:  cover property (inc_v[0] && e0.pres == PRES_BOTH);
  nak_c:      cover property (sie_nak && e0.auto_tx_management && e0.pres != 2'b00);

endmodule // tx_fifo_data_set_flags
